// file: shared/mip_pkg.sv
// Constants and types shared by the interrupt source and priority logic
package mip_pkg;
    // Register byte addresses on the AHB-Lite slave
    localparam logic [7:0] ADDR_PRIO3 = 8'h00;
    localparam logic [7:0] ADDR_RCTL = 8'h04;
    localparam logic [7:0] ADDR_CTL1 = 8'h08;
    localparam logic [7:0] ADDR_CTL2 = 8'h0C;
    localparam logic [7:0] ADDR_CTL3 = 8'h10;
    localparam logic [7:0] ADDR_STACK = 8'h14;
    localparam logic [7:0] ADDR_FAST = 8'h18;

    // Field positions
    localparam int PWM_PRIO_BIT = 4;
    localparam int PRIO_LVL_BIT = 7;
    localparam int SBOR_BIT = 6;
    localparam int INSTR_BIT = 4;
    localparam int DOG_BIT = 3;
    localparam int SLEEP_BIT = 2;
    localparam int POR_BIT = 1;
    localparam int BROWN_BIT = 0;
    localparam int GLOBAL_BIT = 7;
    localparam int LOW_EN_BIT = 6;
    localparam int T0_EN_BIT = 5;
    localparam int X0_EN_BIT = 4;
    localparam int PC_EN_BIT = 3;
    localparam int T0_FLAG_BIT = 2;
    localparam int X0_FLAG_BIT = 1;
    localparam int PC_FLAG_BIT = 0;
    localparam int EDGE0_BIT = 6;
    localparam int EDGE1_BIT = 5;
    localparam int EDGE2_BIT = 4;
    localparam int EDGE3_BIT = 3;
    localparam int T0_PRIO_BIT = 2;
    localparam int X3_PRIO_BIT = 1;
    localparam int PC_PRIO_BIT = 0;
    localparam int X2_PRIO_BIT = 7;
    localparam int X1_PRIO_BIT = 6;
    localparam int X1_EN_BIT = 3;
    localparam int X1_FLAG_BIT = 0;

    // Values after reset
    localparam logic PWM_PRIO_RST = 1'b1;
    localparam logic PRIO_LVL_RST = 1'b0;
    localparam logic INSTR_RST = 1'b1;
    localparam logic DOG_RST = 1'b1;
    localparam logic SLEEP_RST = 1'b1;
    localparam logic BROWN_RST = 1'b0;
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h7F;
    localparam logic [7:0] CTL3_RST = 8'hC0;

    // Return-address stack
    localparam int STACK_DEPTH = 4;
    localparam int PC_W = 21;

    typedef enum {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT} mip_bus_t;
endpackage

// file: logic/mip_irq_logic.sv
// Interrupt flags, priority arbitration, wake-up and context capture with AHB-Lite registers
//
// Overview of operation
// - Priority register 3 holds only bit 4, PWM time-base priority; rest read zero.
// - Control bit 7 enables two priority levels; zero means single level; resets zero.
// - Reset-cause flags at bits 4..0; time-out and power-down read-only; bit 5 zero.
// - Software brown-out enable resets to one when configured on, else zero.
// - Power-on status bit reset value depends on which kind of reset happened.
// - External pins are edge-triggered: select one means rising, zero means falling.
// - Selected edge sets the pin flag; request passes only while its enable is set.
// - External interrupt wakes from low power if enabled before low power began.
// - After wake, vector when global enable set, otherwise just resume.
// - External 1, 2, 3 priorities come from control 3 bits 6, 7 and control 2 bit 1.
// - External 0 has no priority bit and is always high priority.
// - Timer 0 flag sets on FFh to 00h, or FFFFh to 0000h in 16-bit mode.
// - Timer 0 request gated by control 1 bit 5; priority from control 2 bit 2.
// - Pin change flag on the four port pins; enable bit 3, priority control 2 bit 0.
// - Taking an interrupt pushes the return address onto the hardware stack.
// - Taking an interrupt copies working, status and bank select into fast stack.
// - Individual priority bits count only while priority levels are enabled.
module mip_irq_logic
    import mip_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Reset cause
    input wire logic powerOnRst,
    input wire logic brownoutCfgEn,
    input wire logic dogExpiryEvent,
    // Interrupt sources
    input wire logic [3:0] extPins,
    input wire logic [15:0] tmr0Value,
    input wire logic tmr0Wide,
    input wire logic pwmTbFlag,
    input wire logic pwmTbEn,
    // Core side
    input wire logic coreLowPower,
    input wire logic irqTake,
    input wire logic retPop,
    input wire logic [PC_W-1:0] retPc,
    input wire logic [7:0] workingIn,
    input wire logic [7:0] statusIn,
    input wire logic [7:0] bankSelIn,
    output logic irqHigh_r,
    output logic irqLow_r,
    output logic wakeReq_r,
    output logic wakeVector_r,
    output logic [PC_W-1:0] topPc_r,
    output logic [7:0] fastWorking_r,
    output logic [7:0] fastStatus_r,
    output logic [7:0] fastBank_r
);
    mip_bus_t busState_r;
    logic [7:0] busAddr_r;
    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic pwmPrio_r;
    logic prioLvl_r, sbor_r, instrFlag_r, dogFlag_r, sleepFlag_r, por_r, brownFlag_r;
    logic [7:0] ctl1_r, ctl2_r, ctl3_r;
    logic [7:0] ctl1_nxt, ctl2_nxt, ctl3_nxt;
    logic [3:0] extPrev_r;
    logic [15:0] tmr0Prev_r;
    logic lowPrev_r;
    logic [3:0] enSnap_r;
    logic [PC_W-1:0] stack_r [STACK_DEPTH];
    logic [2:0] stackPtr_r;
    logic addrPhase, wrCommit;
    logic [3:0] edgeSel, edgeHit, extFlags, extEns;
    logic changeHit, t0Roll;
    logic [6:0] pend, prio;
    logic reqHigh, reqLow;

    function automatic logic rolled(input logic [15:0] prev, input logic [15:0] cur,
                                    input logic wide);
        if (wide)
            rolled = (prev == 16'hFFFF) && (cur == 16'h0000);
        else
            rolled = (prev[7:0] == 8'hFF) && (cur[7:0] == 8'h00);
    endfunction

    function automatic logic [31:0] readMux(input logic [7:0] addr);
        case (addr)
            ADDR_PRIO3: readMux = {27'h0000000, pwmPrio_r, 4'h0};
            ADDR_RCTL: readMux = {24'h000000, prioLvl_r, sbor_r, 1'b0, instrFlag_r, dogFlag_r,
                                  sleepFlag_r, por_r, brownFlag_r};
            ADDR_CTL1: readMux = {24'h000000, ctl1_r};
            ADDR_CTL2: readMux = {24'h000000, 1'b0, ctl2_r[6:0]};
            ADDR_CTL3: readMux = {24'h000000, ctl3_r};
            ADDR_STACK: readMux = {11'h000, topPc_r};
            ADDR_FAST: readMux = {8'h00, fastBank_r, fastStatus_r, fastWorking_r};
            default: readMux = 32'h00000000;
        endcase
    endfunction

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;
    assign addrPhase = hsel && htrans[1] && hready;
    assign wrCommit = (busState_r == BUS_WRITE);

    // Reads take one wait state so read data comes from a flop and any
    // write in the preceding data phase is already visible.
    always_ff @(posedge clock) begin
        if (rst) begin
            busState_r <= BUS_IDLE;
            busAddr_r <= 8'h00;
            hreadyout_r <= 1'b1;
            hrdata_r <= 32'h00000000;
        end else begin
            case (busState_r)
                BUS_READ_WAIT: begin
                    hrdata_r <= readMux(busAddr_r);
                    hreadyout_r <= 1'b1;
                    busState_r <= BUS_IDLE;
                end
                default: begin
                    if (addrPhase) begin
                        busAddr_r <= haddr[7:0];
                        busState_r <= hwrite ? BUS_WRITE : BUS_READ_WAIT;
                        hreadyout_r <= hwrite;
                    end else begin
                        busState_r <= BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // Edge and change detection on the four pins
    always_comb begin
        edgeSel = {ctl2_r[EDGE3_BIT], ctl2_r[EDGE2_BIT], ctl2_r[EDGE1_BIT], ctl2_r[EDGE0_BIT]};
        edgeHit = (extPins & ~extPrev_r & edgeSel) | (~extPins & extPrev_r & ~edgeSel);
        changeHit = |(extPins ^ extPrev_r);
        t0Roll = rolled(tmr0Prev_r, tmr0Value, tmr0Wide);
    end

    // Hardware sets win over a software write in the same cycle
    always_comb begin
        ctl1_nxt = (wrCommit && busAddr_r == ADDR_CTL1) ? hwdata[7:0] : ctl1_r;
        ctl1_nxt[T0_FLAG_BIT] = ctl1_nxt[T0_FLAG_BIT] | t0Roll;
        ctl1_nxt[X0_FLAG_BIT] = ctl1_nxt[X0_FLAG_BIT] | edgeHit[0];
        ctl1_nxt[PC_FLAG_BIT] = ctl1_nxt[PC_FLAG_BIT] | changeHit;
        ctl2_nxt = (wrCommit && busAddr_r == ADDR_CTL2) ? {1'b0, hwdata[6:0]} : ctl2_r;
        ctl3_nxt = (wrCommit && busAddr_r == ADDR_CTL3) ? hwdata[7:0] : ctl3_r;
        ctl3_nxt[X1_FLAG_BIT+2:X1_FLAG_BIT] = ctl3_nxt[X1_FLAG_BIT+2:X1_FLAG_BIT]
                                              | edgeHit[3:1];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctl1_r <= CTL1_RST;
            ctl2_r <= CTL2_RST;
            ctl3_r <= CTL3_RST;
            extPrev_r <= extPins;
            tmr0Prev_r <= tmr0Value;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            ctl3_r <= ctl3_nxt;
            extPrev_r <= extPins;
            tmr0Prev_r <= tmr0Value;
        end
    end

    // Priority register 3 and reset control register
    always_ff @(posedge clock) begin
        if (rst) begin
            pwmPrio_r <= PWM_PRIO_RST;
            prioLvl_r <= PRIO_LVL_RST;
            sbor_r <= brownoutCfgEn;
            instrFlag_r <= INSTR_RST;
            dogFlag_r <= DOG_RST;
            sleepFlag_r <= SLEEP_RST;
            if (powerOnRst)
                por_r <= 1'b0;
            brownFlag_r <= BROWN_RST;
        end else begin
            if (wrCommit && busAddr_r == ADDR_PRIO3)
                pwmPrio_r <= hwdata[PWM_PRIO_BIT];
            if (wrCommit && busAddr_r == ADDR_RCTL) begin
                prioLvl_r <= hwdata[PRIO_LVL_BIT];
                sbor_r <= hwdata[SBOR_BIT];
                instrFlag_r <= hwdata[INSTR_BIT];
                por_r <= hwdata[POR_BIT];
                brownFlag_r <= hwdata[BROWN_BIT];
            end
            // Time-out and power-down are changed by hardware only
            if (dogExpiryEvent)
                dogFlag_r <= 1'b0;
            if (coreLowPower && !lowPrev_r)
                sleepFlag_r <= 1'b0;
        end
    end

    // Source vector: ext0, ext1, ext2, ext3, timer 0, pin change, PWM time base
    always_comb begin
        extFlags = {ctl3_r[X1_FLAG_BIT+2:X1_FLAG_BIT], ctl1_r[X0_FLAG_BIT]};
        extEns = {ctl3_r[X1_EN_BIT+2:X1_EN_BIT], ctl1_r[X0_EN_BIT]};
        pend = {pwmTbFlag & pwmTbEn,
                ctl1_r[PC_FLAG_BIT] & ctl1_r[PC_EN_BIT],
                ctl1_r[T0_FLAG_BIT] & ctl1_r[T0_EN_BIT],
                extFlags & extEns};
        prio = {pwmPrio_r, ctl2_r[PC_PRIO_BIT], ctl2_r[T0_PRIO_BIT],
                ctl2_r[X3_PRIO_BIT], ctl3_r[X2_PRIO_BIT], ctl3_r[X1_PRIO_BIT],
                1'b1};
        if (prioLvl_r) begin
            reqHigh = ctl1_r[GLOBAL_BIT] && |(pend & prio);
            reqLow = ctl1_r[GLOBAL_BIT] && ctl1_r[LOW_EN_BIT] && |(pend & ~prio);
        end else begin
            // Single level: priority bits ignored, time base also needs the low enable
            reqHigh = ctl1_r[GLOBAL_BIT]
                      && (|pend[5:0] || (ctl1_r[LOW_EN_BIT] && pend[6]));
            reqLow = 1'b0;
        end
    end

    // Requests and wake-up toward the core
    always_ff @(posedge clock) begin
        if (rst) begin
            irqHigh_r <= 1'b0;
            irqLow_r <= 1'b0;
            lowPrev_r <= 1'b0;
            enSnap_r <= 4'h0;
            wakeReq_r <= 1'b0;
            wakeVector_r <= 1'b0;
        end else begin
            irqHigh_r <= reqHigh;
            irqLow_r <= reqLow;
            lowPrev_r <= coreLowPower;
            // Enables written after entry do not arm the wake path
            if (coreLowPower && !lowPrev_r)
                enSnap_r <= extEns;
            wakeReq_r <= coreLowPower && lowPrev_r && |(extFlags & enSnap_r);
            wakeVector_r <= coreLowPower && lowPrev_r && |(extFlags & enSnap_r)
                            && ctl1_r[GLOBAL_BIT];
        end
    end

    // Context capture; a push when full is dropped, push beats pop
    always_ff @(posedge clock) begin
        if (rst) begin
            stackPtr_r <= 3'h0;
            topPc_r <= '0;
            fastWorking_r <= 8'h00;
            fastStatus_r <= 8'h00;
            fastBank_r <= 8'h00;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_r[i] <= '0;
        end else if (irqTake) begin
            fastWorking_r <= workingIn;
            fastStatus_r <= statusIn;
            fastBank_r <= bankSelIn;
            if (stackPtr_r < 3'(STACK_DEPTH)) begin
                stack_r[stackPtr_r[1:0]] <= retPc;
                stackPtr_r <= stackPtr_r + 3'h1;
                topPc_r <= retPc;
            end
        end else if (retPop && stackPtr_r != 3'h0) begin
            stackPtr_r <= stackPtr_r - 3'h1;
            topPc_r <= (stackPtr_r >= 3'h2) ? stack_r[2'(stackPtr_r - 3'h2)] : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_prio3_read;
        busState_r == BUS_READ_WAIT && busAddr_r == ADDR_PRIO3
        |=> hrdata_r[31:5] == 27'h0000000 && hrdata_r[3:0] == 4'h0
            && hrdata_r[4] == $past(pwmPrio_r);
    endproperty
    a_prio3_read: assert property (p_prio3_read) else $error("bad priority 3 read");

    property p_lvl_reset;
        $fell(rst) |-> !prioLvl_r && !irqLow_r;
    endproperty
    a_lvl_reset: assert property (p_lvl_reset) else $error("levels on after reset");

    property p_to_readonly;
        wrCommit && busAddr_r == ADDR_RCTL && !dogExpiryEvent |=> dogFlag_r == $past(dogFlag_r);
    endproperty
    a_to_readonly: assert property (p_to_readonly) else $error("time-out bit written");

    property p_sbor_reset;
        $fell(rst) |-> sbor_r == $past(brownoutCfgEn);
    endproperty
    a_sbor_reset: assert property (p_sbor_reset) else $error("bad brown-out enable");

    property p_por_reset;
        $fell(rst) && $past(powerOnRst) |-> !por_r;
    endproperty
    a_por_reset: assert property (p_por_reset) else $error("power-on bit not cleared");

    property p_ext0_edge;
        extPins[0] != extPrev_r[0] && extPins[0] == ctl2_r[EDGE0_BIT] |=> ctl1_r[X0_FLAG_BIT];
    endproperty
    a_ext0_edge: assert property (p_ext0_edge) else $error("edge did not set flag");

    property p_wake;
        coreLowPower && lowPrev_r && (extFlags & enSnap_r) != 4'h0
        |=> wakeReq_r && wakeVector_r == $past(ctl1_r[GLOBAL_BIT]);
    endproperty
    a_wake: assert property (p_wake) else $error("missed or wrong wake");

    property p_ext0_high;
        prioLvl_r && ctl1_r[GLOBAL_BIT] && ctl1_r[X0_EN_BIT] && ctl1_r[X0_FLAG_BIT] |=> irqHigh_r;
    endproperty
    a_ext0_high: assert property (p_ext0_high) else $error("ext 0 not high");

    property p_t0_roll;
        t0Roll |=> ctl1_r[T0_FLAG_BIT] ##1 ctl1_r[T0_FLAG_BIT] || $past(wrCommit);
    endproperty
    a_t0_roll: assert property (p_t0_roll) else $error("timer flag missed");

    property p_push;
        irqTake && stackPtr_r < 3'(STACK_DEPTH)
        |=> topPc_r == $past(retPc) && fastWorking_r == $past(workingIn)
            && stackPtr_r == $past(stackPtr_r) + 3'h1;
    endproperty
    a_push: assert property (p_push) else $error("context not saved");

    property p_no_req;
        pend == 7'h00 |=> !irqHigh_r && !irqLow_r;
    endproperty
    a_no_req: assert property (p_no_req) else $error("request without source");
endmodule // mip_irq_logic

// file: tb/mip_core_model.sv
// Behavioural core: takes interrupts, supplies context, sleeps and wakes
module mip_core_model
    import mip_pkg::*;
(
    // Clock, reset and bench controls
    input wire logic clock,
    input wire logic rst,
    input wire logic takeEn,
    input wire logic sleepReq,
    input wire logic popReq,
    // Requests from the block
    input wire logic irqHigh,
    input wire logic irqLow,
    input wire logic wakeReq,
    input wire logic wakeVector,
    // Core state towards the block
    output logic irqTake,
    output logic retPop,
    output logic coreLowPower,
    output logic [PC_W-1:0] retPc,
    output logic [7:0] workingIn,
    output logic [7:0] statusIn,
    output logic [7:0] bankSelIn,
    // Last wake seen: {woke, vectored}
    output logic [1:0] wakeSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic inService;
    logic slept;

    always_ff @(posedge clock) begin
        if (rst) begin
            irqTake <= 1'b0;
            inService <= 1'b0;
            retPc <= 21'h01000;
            workingIn <= 8'h5A;
            statusIn <= 8'h13;
            bankSelIn <= 8'h02;
        end else begin
            // One take per request; the handler clears the flag before another
            irqTake <= takeEn && (irqHigh || irqLow) && !inService && !irqTake;
            if (irqTake) begin
                inService <= 1'b1;
                retPc <= retPc + 21'h00104;
                // Handler code moves these on and saves them itself when needed
                workingIn <= ~workingIn;
                statusIn <= statusIn + 8'h21;
                bankSelIn <= bankSelIn + 8'h01;
            end else if (!irqHigh && !irqLow) begin
                inService <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        retPop <= !rst && popReq;
    end

    // Sleeps once per request; a wake ends it and is remembered for the bench
    always_ff @(posedge clock) begin
        if (rst) begin
            coreLowPower <= 1'b0;
            slept <= 1'b0;
            wakeSeen <= 2'b00;
        end else if (!sleepReq) begin
            coreLowPower <= 1'b0;
            slept <= 1'b0;
        end else if (!slept) begin
            coreLowPower <= 1'b1;
            slept <= 1'b1;
            wakeSeen <= 2'b00;
        end else if (coreLowPower && wakeReq) begin
            coreLowPower <= 1'b0;
            wakeSeen <= {1'b1, wakeVector};
        end
    end
endmodule // mip_core_model

// file: tb/test_mcu_interrupt_priority_logic.sv
// Self-checking bench for the interrupt source and priority logic
module test_mcu_interrupt_priority_logic
    import mip_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, hsel, hwrite, hreadyout, hresp, powerOnRst, brownoutCfgEn, tmr0Wide;
    logic takeEn, sleepReq, popReq, irqTake, retPop, coreLowPower, dogExpiry, pwmTb;
    logic irqHigh_r, irqLow_r, wakeReq_r, wakeVector_r;
    logic [31:0] haddr, hwdata, hrdata, rd, ctl1, ctl3;
    logic [1:0] htrans, wakeSeen;
    logic [3:0] extPins;
    logic [15:0] tmr0Value;
    logic [PC_W-1:0] retPc, topPc_r, lastPc, prevPc;
    logic [7:0] workingIn, statusIn, bankSelIn, fastWorking_r, fastStatus_r, fastBank_r;
    logic [23:0] lastCtx;
    int nFail, cmpCount;

    mip_irq_logic dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .powerOnRst(powerOnRst),
        .brownoutCfgEn(brownoutCfgEn), .dogExpiryEvent(dogExpiry), .extPins(extPins),
        .tmr0Value(tmr0Value), .tmr0Wide(tmr0Wide), .pwmTbFlag(pwmTb), .pwmTbEn(pwmTb),
        .coreLowPower(coreLowPower), .irqTake(irqTake), .retPop(retPop), .retPc(retPc),
        .workingIn(workingIn), .statusIn(statusIn), .bankSelIn(bankSelIn),
        .irqHigh_r(irqHigh_r), .irqLow_r(irqLow_r), .wakeReq_r(wakeReq_r),
        .wakeVector_r(wakeVector_r), .topPc_r(topPc_r), .fastWorking_r(fastWorking_r),
        .fastStatus_r(fastStatus_r), .fastBank_r(fastBank_r));
    mip_core_model core (.clock(clock), .rst(rst), .takeEn(takeEn), .sleepReq(sleepReq),
        .popReq(popReq), .irqHigh(irqHigh_r), .irqLow(irqLow_r), .wakeReq(wakeReq_r),
        .wakeVector(wakeVector_r), .irqTake(irqTake), .retPop(retPop),
        .coreLowPower(coreLowPower), .retPc(retPc), .workingIn(workingIn),
        .statusIn(statusIn), .bankSelIn(bankSelIn), .wakeSeen(wakeSeen));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Context offered at each take, kept as the expected stack contents
    always @(posedge clock) begin
        if (irqTake === 1'b1) begin
            prevPc <= lastPc;
            lastPc <= retPc;
            lastCtx <= {bankSelIn, statusIn, workingIn};
        end
    end

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nFail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // No cycle limit of its own: a slave that never answers is caught by the watchdog
    task automatic waitReady;
        do begin
            @(posedge clock);
        end while (hreadyout !== 1'b1);
    endtask

    task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        waitReady();
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
        rd = hrdata;
    endtask

    task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
        busXfer(1'b1, a, d);
    endtask

    task automatic readCheck(input logic [7:0] a, input logic [31:0] exp);
        busXfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic setPin(input int i, input logic v);
        @(posedge clock);
        extPins[i] <= v;
        repeat (4) @(posedge clock);
    endtask

    // Software clears flags by writing the enables back with flags at zero
    task automatic clearFlags;
        busWrite(ADDR_CTL1, ctl1);
        busWrite(ADDR_CTL3, ctl3);
    endtask

    task automatic irqIs(input logic hi, input logic lo);
        check({30'h0, irqHigh_r, irqLow_r}, {30'h0, hi, lo});
    endtask

    task automatic testRegs;
        readCheck(ADDR_PRIO3, 32'h10);
        readCheck(ADDR_RCTL, 32'h5C);
        busWrite(ADDR_PRIO3, 32'hFF);
        readCheck(ADDR_PRIO3, 32'h10);
        busWrite(ADDR_PRIO3, 32'h00);
        readCheck(ADDR_PRIO3, 32'h00);
        busWrite(ADDR_RCTL, 32'hFF);
        readCheck(ADDR_RCTL, 32'hDF);
        readCheck(8'h40, 32'h0);
        @(posedge clock);
        rst <= 1'b1;
        powerOnRst <= 1'b0;
        brownoutCfgEn <= 1'b0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        readCheck(ADDR_RCTL, 32'h1E);
        busWrite(ADDR_RCTL, 32'h00);
        readCheck(ADDR_RCTL, 32'h0C);
        @(posedge clock);
        dogExpiry <= 1'b1;
        @(posedge clock);
        dogExpiry <= 1'b0;
        readCheck(ADDR_RCTL, 32'h04);
    endtask

    task automatic testEdges;
        clearFlags();
        for (int s = 0; s < 2; s++) begin
            busWrite(ADDR_CTL2, (s == 1) ? 32'h78 : 32'h00);
            for (int i = 0; i < 4; i++) begin
                setPin(i, 1'b1);
                readCheck(ADDR_CTL1, ctl1 | {30'h0, (s == 1 && i == 0), 1'b1});
                readCheck(ADDR_CTL3, (s == 1 && i > 0) ? 32'h1 << (i - 1) : 32'h0);
                irqIs(1'b0, 1'b0);
                clearFlags();
                setPin(i, 1'b0);
                readCheck(ADDR_CTL1, ctl1 | {30'h0, (s == 0 && i == 0), 1'b1});
                readCheck(ADDR_CTL3, (s == 0 && i > 0) ? 32'h1 << (i - 1) : 32'h0);
                clearFlags();
            end
        end
    endtask

    task automatic testPrio;
        busWrite(ADDR_RCTL, 32'h90);
        // Time-base source starts at high priority after the mid-run reset
        pwmTb <= 1'b1;
        repeat (3) @(posedge clock);
        irqIs(1'b1, 1'b0);
        busWrite(ADDR_PRIO3, 32'h00);
        repeat (2) @(posedge clock);
        irqIs(1'b0, 1'b1);
        pwmTb <= 1'b0;
        for (int k = 1; k < 4; k++) begin
            for (int p = 0; p < 2; p++) begin
                ctl3 = (32'h1 << (k + 2)) | ((k == 1 && p == 1) ? 32'h40 : 32'h0);
                ctl3 = ctl3 | ((k == 2 && p == 1) ? 32'h80 : 32'h0);
                busWrite(ADDR_CTL2, (k == 3 && p == 1) ? 32'h7A : 32'h78);
                clearFlags();
                setPin(k, 1'b1);
                irqIs(p == 1, p == 0);
                setPin(k, 1'b0);
                clearFlags();
                repeat (2) @(posedge clock);
                irqIs(1'b0, 1'b0);
            end
        end
        ctl3 = 32'h0;
        ctl1 = 32'hD0;
        busWrite(ADDR_CTL2, 32'h78);
        clearFlags();
        setPin(0, 1'b1);
        irqIs(1'b1, 1'b0);
        setPin(0, 1'b0);
        ctl1 = 32'hE0;
        clearFlags();
        @(posedge clock);
        tmr0Value <= 16'h00FF;
        @(posedge clock);
        tmr0Value <= 16'h0000;
        repeat (4) @(posedge clock);
        irqIs(1'b0, 1'b1);
        busWrite(ADDR_CTL2, 32'h7C);
        clearFlags();
        tmr0Wide <= 1'b1;
        tmr0Value <= 16'h00FF;
        @(posedge clock);
        tmr0Value <= 16'h0100;
        repeat (4) @(posedge clock);
        readCheck(ADDR_CTL1, 32'hE0);
        tmr0Value <= 16'hFFFF;
        @(posedge clock);
        tmr0Value <= 16'h0000;
        repeat (4) @(posedge clock);
        irqIs(1'b1, 1'b0);
        ctl1 = 32'hC8;
        busWrite(ADDR_CTL2, 32'h79);
        clearFlags();
        setPin(2, 1'b1);
        irqIs(1'b1, 1'b0);
        busWrite(ADDR_CTL2, 32'h78);
        clearFlags();
        setPin(2, 1'b0);
        irqIs(1'b0, 1'b1);
        busWrite(ADDR_RCTL, 32'h10);
        ctl1 = 32'hC0;
        ctl3 = 32'h08;
        clearFlags();
        setPin(1, 1'b1);
        irqIs(1'b1, 1'b0);
        setPin(1, 1'b0);
    endtask

    task automatic sleepCase(input logic [31:0] c1, input logic [2:0] exp);
        ctl1 = c1;
        ctl3 = 32'h0;
        clearFlags();
        sleepReq <= 1'b1;
        repeat (3) @(posedge clock);
        setPin(0, 1'b1);
        repeat (2) @(posedge clock);
        check({29'h0, wakeSeen, coreLowPower}, {29'h0, exp});
        sleepReq <= 1'b0;
        setPin(0, 1'b0);
    endtask

    task automatic testContext;
        ctl1 = 32'h90;
        clearFlags();
        takeEn <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            setPin(0, 1'b1);
            repeat (3) @(posedge clock);
            check({11'h0, topPc_r}, {11'h0, lastPc});
            check({8'h0, fastBank_r, fastStatus_r, fastWorking_r}, {8'h0, lastCtx});
            setPin(0, 1'b0);
            clearFlags();
        end
        readCheck(ADDR_FAST, {8'h0, lastCtx});
        takeEn <= 1'b0;
        popReq <= 1'b1;
        @(posedge clock);
        popReq <= 1'b0;
        readCheck(ADDR_STACK, {11'h0, prevPc});
    endtask

    initial begin
        {rst, hsel, powerOnRst, brownoutCfgEn} = 4'hF;
        {hwrite, tmr0Wide, takeEn, sleepReq, popReq, dogExpiry, pwmTb} = 7'h00;
        {haddr, hwdata, ctl3} = 96'h0;
        ctl1 = 32'hC0;
        htrans = 2'h0;
        extPins = 4'h0;
        tmr0Value = 16'h0000;
        nFail = 0;
        cmpCount = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        testRegs();
        testEdges();
        testPrio();
        sleepCase(32'h10, 3'b100);
        sleepCase(32'h90, 3'b110);
        sleepCase(32'h80, 3'b001);
        testContext();
        final_report();
    end

    // Whole run needs well under 20000 cycles; a hang is cut short here
    initial begin
        repeat (20000) @(posedge clock);
        nFail++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule // test_mcu_interrupt_priority_logic
